// ===== hdl/calendar_clock_regs.vh
/*
 Register offsets, control field positions, reset values and divider
 ratios of the calendar clock. Definitions only; included by bare name.
*/
`ifndef CALENDAR_CLOCK_REGS_VH
`define CALENDAR_CLOCK_REGS_VH

// Low byte of the I/O address
`define OFS_SECONDS 8'he0
`define OFS_MIN 8'he1
`define OFS_HRS 8'he2
`define OFS_DOW 8'he3
`define OFS_DOM 8'he4
`define OFS_MON 8'he5
`define OFS_YR 8'he6
`define OFS_CEN 8'he7
`define OFS_ASEC 8'he8
`define OFS_AMIN 8'he9
`define OFS_AHRS 8'hea
`define OFS_ADOW 8'heb
`define OFS_ACTRL 8'hec
`define OFS_CTRL 8'hed

// Clock control fields
`define CTRL_UNLOCK 0
`define CTRL_CLK_SEL 1
`define CTRL_FREQ_SEL 2
`define CTRL_BCD_EN 3
`define CTRL_INT_EN 4
`define CTRL_ALARM 5

// Alarm control fields
`define ACTRL_SECONDS_EN 0
`define ACTRL_MIN_EN 1
`define ACTRL_HRS_EN 2
`define ACTRL_DOW_EN 3

`define CTRL_RESET 5'h00
`define ACTRL_RESET 4'h0

// Source edges per second
`define OSC_EDGES 16'd32768
`define LINE50_EDGES 16'd50
`define LINE60_EDGES 16'd60

`endif

// ===== hdl/calendar_clock_with_alarm.v
/*
 Calendar clock with alarm: seconds through century, binary or BCD
 presentation, leap years, four-field alarm, one-second divider fed by a
 32 kHz oscillator or a 50/60 Hz line input on the crystal-out pin.
 Assumes a synchronous I/O port on core_clk with one-cycle read and write
 strobes; both timing sources are asynchronous pins.

 // Behaviour
 // - Separate seconds to century counts advance together as one time value.
 // - Hours run 0 to 23, no AM/PM.
 // - All count and alarm registers read and write in binary or BCD.
 // - Day-of-month wraps at true month length, February 29 in leap years.
 // - Four alarm set-points with enables; alarm when all enabled ones match.
 // - Alarm sets flag; interrupt request only while interrupt enable set.
 // - Reading clock control clears alarm flag and pending interrupt.
 // - Alarm set-points and enables are writable whatever the lock bit.
 // - Alarm compare happens after each once-per-second count increment.
 // - Writing lock bit 0 forces an immediate alarm compare.
 // - Second tick from divider on oscillator or line input, ratio per selection.
 // - Every clock control write restarts the divider.
 // - Clearing the lock bit resets the divider and lets it run.
 // - Lock bit 1 stops counting, counts writable; 0 counts, writes ignored.
 // - System reset leaves the lock bit in the locked state.
 // - Reset clears alarm enables; counts undefined until software writes them.
 // - Seconds count is not changed by system reset.
 // - Format bit 0 gives binary, 1 gives BCD.
 // - BCD seconds: tens 0-5 in [7:4], ones in [3:0]; binary 00h-3Bh.
 // - Day-of-week cycles 1 to 7; day-of-month starts at 1.
*/
`timescale 1ns/1ns
`default_nettype none
`include "calendar_clock_regs.vh"

module calendar_clock_with_alarm #(
   parameter [15:0] OSC_DIV = `OSC_EDGES
) (
   input wire core_clk,
   input wire reset_n,
   input wire [7:0] io_addr,
   input wire io_wr,
   input wire io_rd,
   input wire [7:0] io_wdata,
   output reg [7:0] io_rdata,
   output reg irq,
   input wire osc_32k,
   input wire crystal_out_pin
);

   reg [6:0] lowest_time_unit_count;
   reg [6:0] min;
   reg [6:0] hrs;
   reg [6:0] weekday_count;
   reg [6:0] dom;
   reg [6:0] mon;
   reg [6:0] yr;
   reg [6:0] cen;
   reg [6:0] a_seconds;
   reg [6:0] a_min;
   reg [6:0] a_hrs;
   reg [6:0] a_dow;
   reg [3:0] alarm_en;
   reg unlock;
   reg clk_sel;
   reg freq_sel;
   reg bcd_en;
   reg int_en;
   reg alarm_flag;
   reg cmp_req;
   reg osc_s1;
   reg osc_s2;
   reg osc_prev;
   reg line_s1;
   reg line_s2;
   reg line_prev;
   reg [15:0] div_cnt;
   reg tick;
   reg [6:0] mdays;
   reg [7:0] next_rdata;
   wire ctrl_wr;
   wire ctrl_rd;
   wire src_edge;
   wire [15:0] div_limit;
   wire leap;
   wire [6:0] wr_val;
   wire [3:0] match;
   wire alarm_hit;
   wire alarm_set;
   wire [27:0] alarm_points;
   wire [27:0] alarm_counts;
   genvar field;

   // Counts are kept binary; the format bit only changes how they are seen
   function [7:0] to_fmt;
      input [6:0] v;
      input bcd;
      reg [6:0] t;
      reg [6:0] o;
      begin
         t = v / 7'd10;
         o = v - t * 7'd10;
         to_fmt = bcd ? {t[3:0], o[3:0]} : {1'b0, v};
      end
   endfunction

   // Bad BCD digits are not checked; tens times ten plus ones is stored, past-range values wrap at the next carry
   function [6:0] from_fmt;
      input [7:0] d;
      input bcd;
      begin
         from_fmt = bcd ? ({3'b000, d[7:4]} * 7'd10 + {3'b000, d[3:0]}) : d[6:0];
      end
   endfunction

   assign ctrl_wr = io_wr && (io_addr == `OFS_CTRL);
   assign ctrl_rd = io_rd && (io_addr == `OFS_CTRL);
   assign wr_val = from_fmt(io_wdata, bcd_en);

   // Both sources are pins; two stages before the edge detector
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_prev <= 1'b0;
         line_s1 <= 1'b0;
         line_s2 <= 1'b0;
         line_prev <= 1'b0;
      end else begin
         osc_s1 <= osc_32k;
         osc_s2 <= osc_s1;
         osc_prev <= osc_s2;
         line_s1 <= crystal_out_pin;
         line_s2 <= line_s1;
         line_prev <= line_s2;
      end
   end

   assign src_edge = clk_sel ? (line_s2 & ~line_prev) : (osc_s2 & ~osc_prev);
   assign div_limit = clk_sel ? (freq_sel ? `LINE50_EDGES : `LINE60_EDGES) : OSC_DIV;

   // Divider; a source switch is a control write, so the count restarts from zero
   // Line ratios are fixed; only the oscillator ratio is a parameter
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (ctrl_wr) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (src_edge) begin
         if (div_cnt >= div_limit - 16'h0001) begin
            div_cnt <= 16'h0000;
            tick <= 1'b1;
         end else begin
            div_cnt <= div_cnt + 16'h0001;
            tick <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end

   // Year 00 is a leap year only when the century is a multiple of four
   assign leap = (yr[1:0] == 2'b00) && ((yr != 7'h00) || (cen[1:0] == 2'b00));

   always @* begin
      case (mon)
         7'h02: mdays = leap ? 7'h1d : 7'h1c;
         7'h04, 7'h06, 7'h09, 7'h0b: mdays = 7'h1e;
         default: mdays = 7'h1f;
      endcase
   end

   // Counts hold no reset: they survive system reset
   // Unlocked: frozen and writable; the divider keeps running
   always @(posedge core_clk) begin
      if (unlock) begin
         if (io_wr) begin
            if (io_addr == `OFS_SECONDS) begin
               lowest_time_unit_count <= wr_val;
            end else if (io_addr == `OFS_MIN) begin
               min <= wr_val;
            end else if (io_addr == `OFS_HRS) begin
               hrs <= wr_val;
            end else if (io_addr == `OFS_DOW) begin
               weekday_count <= {3'b000, io_wdata[3:0]};
            end else if (io_addr == `OFS_DOM) begin
               dom <= wr_val;
            end else if (io_addr == `OFS_MON) begin
               mon <= wr_val;
            end else if (io_addr == `OFS_YR) begin
               yr <= wr_val;
            end else if (io_addr == `OFS_CEN) begin
               cen <= wr_val;
            end
         end
      end else if (tick) begin
         if (lowest_time_unit_count < 7'd59) begin
            lowest_time_unit_count <= lowest_time_unit_count + 7'd1;
         end else begin
            lowest_time_unit_count <= 7'd0;
            if (min < 7'd59) begin
               min <= min + 7'd1;
            end else begin
               min <= 7'd0;
               if (hrs < 7'd23) begin
                  hrs <= hrs + 7'd1;
               end else begin
                  hrs <= 7'd0;
                  weekday_count <= (weekday_count >= 7'd7) ? 7'd1 : weekday_count + 7'd1;
                  if (dom < mdays) begin
                     dom <= dom + 7'd1;
                  end else begin
                     dom <= 7'd1;
                     if (mon < 7'd12) begin
                        mon <= mon + 7'd1;
                     end else begin
                        mon <= 7'd1;
                        if (yr < 7'd99) begin
                           yr <= yr + 7'd1;
                        end else begin
                           yr <= 7'd0;
                           cen <= (cen < 7'd99) ? cen + 7'd1 : 7'd0;
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // Set-points keep their value over reset; only the enables clear
   always @(posedge core_clk) begin
      if (io_wr) begin
         if (io_addr == `OFS_ASEC) begin
            a_seconds <= wr_val;
         end else if (io_addr == `OFS_AMIN) begin
            a_min <= wr_val;
         end else if (io_addr == `OFS_AHRS) begin
            a_hrs <= wr_val;
         end else if (io_addr == `OFS_ADOW) begin
            a_dow <= {3'b000, io_wdata[3:0]};
         end
      end
   end

   // Reset locks the clock and clears the enables, not the set-points
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         alarm_en <= `ACTRL_RESET;
         {int_en, bcd_en, freq_sel, clk_sel, unlock} <= `CTRL_RESET;
      end else begin
         if (io_wr && (io_addr == `OFS_ACTRL)) begin
            alarm_en <= io_wdata[3:0];
         end
         if (ctrl_wr) begin
            unlock <= io_wdata[`CTRL_UNLOCK];
            clk_sel <= io_wdata[`CTRL_CLK_SEL];
            freq_sel <= io_wdata[`CTRL_FREQ_SEL];
            bcd_en <= io_wdata[`CTRL_BCD_EN];
            int_en <= io_wdata[`CTRL_INT_EN];
         end
      end
   end

   assign alarm_points = {a_dow, a_hrs, a_min, a_seconds};
   assign alarm_counts = {weekday_count, hrs, min, lowest_time_unit_count};
   // Field order follows the enable bits: seconds, minutes, hours, weekday
   generate
      for (field = 0; field < 4; field = field + 1) begin : g_field
         assign match[field] = ~alarm_en[field] | (alarm_points[7 * field +: 7] == alarm_counts[7 * field +: 7]);
      end
   endgenerate
   // No enabled field means no alarm rather than one every second
   assign alarm_hit = (alarm_en != 4'h0) && (match == 4'hf);
   assign alarm_set = cmp_req & alarm_hit;

   // Compare one cycle after the counts have settled
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmp_req <= 1'b0;
         alarm_flag <= 1'b0;
         irq <= 1'b0;
      end else begin
         cmp_req <= (tick & ~unlock) | (ctrl_wr & ~io_wdata[`CTRL_UNLOCK]);
         if (alarm_set) begin
            alarm_flag <= 1'b1;
         end else if (ctrl_rd) begin
            alarm_flag <= 1'b0;
         end
         irq <= int_en & (alarm_set | (alarm_flag & ~ctrl_rd));
      end
   end

   // Weekday fields are 1 to 7 in either format, upper nibble zero
   always @* begin
      if (io_addr == `OFS_SECONDS) begin
         next_rdata = to_fmt(lowest_time_unit_count, bcd_en);
      end else if (io_addr == `OFS_MIN) begin
         next_rdata = to_fmt(min, bcd_en);
      end else if (io_addr == `OFS_HRS) begin
         next_rdata = to_fmt(hrs, bcd_en);
      end else if (io_addr == `OFS_DOW) begin
         next_rdata = {4'h0, weekday_count[3:0]};
      end else if (io_addr == `OFS_DOM) begin
         next_rdata = to_fmt(dom, bcd_en);
      end else if (io_addr == `OFS_MON) begin
         next_rdata = to_fmt(mon, bcd_en);
      end else if (io_addr == `OFS_YR) begin
         next_rdata = to_fmt(yr, bcd_en);
      end else if (io_addr == `OFS_CEN) begin
         next_rdata = to_fmt(cen, bcd_en);
      end else if (io_addr == `OFS_ASEC) begin
         next_rdata = to_fmt(a_seconds, bcd_en);
      end else if (io_addr == `OFS_AMIN) begin
         next_rdata = to_fmt(a_min, bcd_en);
      end else if (io_addr == `OFS_AHRS) begin
         next_rdata = to_fmt(a_hrs, bcd_en);
      end else if (io_addr == `OFS_ADOW) begin
         next_rdata = {4'h0, a_dow[3:0]};
      end else if (io_addr == `OFS_ACTRL) begin
         next_rdata = {4'h0, alarm_en};
      end else if (io_addr == `OFS_CTRL) begin
         next_rdata = {2'b00, alarm_flag, int_en, bcd_en, freq_sel, clk_sel, unlock};
      end else begin
         next_rdata = 8'h00;
      end
   end

   // Read data is a flop and holds until the next read strobe
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         io_rdata <= next_rdata;
      end
   end

endmodule // calendar_clock_with_alarm
`default_nettype wire

// ===== testbench/calendar_clock_checker.sv
/* Port checker for the calendar clock.
 Assumes a bind onto calendar_clock_with_alarm; one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module calendar_clock_checker #(
   parameter [15:0] OSC_DIV = 16'd4
) (
   input wire core_clk,
   input wire reset_n,
   input wire [7:0] io_addr,
   input wire io_wr,
   input wire io_rd,
   input wire [7:0] io_wdata,
   input wire [7:0] io_rdata,
   input wire irq,
   input wire osc_32k,
   input wire crystal_out_pin
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire rd_ctrl = io_rd && io_addr == 8'hed;
   wire wr_ctrl = io_wr && io_addr == 8'hed;
   sequence int_off_s;
      wr_ctrl && !io_wdata[4] ##1 !wr_ctrl [*2];
   endsequence
   irq_read_clear_a: assert property (rd_ctrl |=> !irq) else $error("irq after control read");
   irq_needs_en_a: assert property (int_off_s |=> !irq) else $error("irq with enable off");
   rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata)) else $error("read data moved");
   unmapped_zero_a: assert property (io_rd && (io_addr < 8'he0 || io_addr > 8'hed) |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   ctrl_top_a: assert property (rd_ctrl |=> io_rdata[7:6] == 2'b00) else $error("control top bits set");
   weekday_range_a: assert property (io_rd && io_addr == 8'he3 |=> io_rdata >= 8'h01 && io_rdata <= 8'h07)
      else $error("weekday out of range");
   hours_range_a: assert property (io_rd && io_addr == 8'he2 |=> io_rdata <= 8'h23)
      else $error("hours out of range");
   seconds_range_a: assert property (io_rd && io_addr == 8'he0 |=>
      io_rdata <= 8'h3b || (io_rdata[7:4] <= 4'h5 && io_rdata[3:0] <= 4'h9)) else $error("seconds bad");
endmodule // calendar_clock_checker
bind calendar_clock_with_alarm calendar_clock_checker #(.OSC_DIV(OSC_DIV)) u_calendar_clock_checker (
   .core_clk(core_clk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
   .io_wdata(io_wdata), .io_rdata(io_rdata), .irq(irq), .osc_32k(osc_32k), .crystal_out_pin(crystal_out_pin));
`default_nettype wire

// ===== testbench/timing_source_model.sv
/* Oscillator and mains line pin model.
 Assumes the bench shortens the oscillator divider; periods off the clock grid. */
`timescale 1ns/1ns
`default_nettype none
module timing_source_model #(
   parameter int OSC_HALF = 21,
   parameter int LINE_HALF = 11
) (
   output logic osc_32k,
   output logic crystal_out_pin
);
   // Free running, like a crystal and a mains feed
   initial begin
      osc_32k = 1'b0;
      forever #(OSC_HALF) osc_32k = ~osc_32k;
   end
   initial begin
      crystal_out_pin = 1'b0;
      forever #(LINE_HALF) crystal_out_pin = ~crystal_out_pin;
   end
endmodule // timing_source_model
`default_nettype wire

// ===== testbench/calendar_clock_with_alarm_tb_top.sv
/* Bench for the calendar clock: register tasks on the I/O port and scenarios.
 Assumes the timing source model and checker beside the design. */
`timescale 1ns/1ns
`default_nettype none
module calendar_clock_with_alarm_tb_top;
   logic core_clk;
   logic reset_n;
   logic [7:0] io_addr;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_wdata;
   wire [7:0] io_rdata;
   wire irq;
   wire osc_32k;
   wire crystal_out_pin;
   int error_cnt;
   int comparisons;
   int e;
   calendar_clock_with_alarm #(.OSC_DIV(16'd4)) u_calendar_clock_with_alarm (.core_clk(core_clk),
      .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .irq(irq), .osc_32k(osc_32k), .crystal_out_pin(crystal_out_pin));
   timing_source_model u_timing_source_model (.osc_32k(osc_32k), .crystal_out_pin(crystal_out_pin));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      #1;
      io_addr = a;
      io_wdata = v;
      io_wr = 1'b1;
      @(posedge core_clk);
      #1;
      io_wr = 1'b0;
   endtask
   task automatic rd_raw(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      #1;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge core_clk);
      #1;
      io_rd = 1'b0;
      v = io_rdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd_raw(a, v);
      check(v, exp);
   endtask
   // Bounded poll: a stuck count fails instead of hanging
   task automatic poll_seconds(input logic [7:0] exp, input int lim);
      logic [7:0] v;
      int n;
      n = 0;
      rd_raw(8'he0, v);
      while (v !== exp && n < lim) begin
         rd_raw(8'he0, v);
         n++;
      end
      check(v, exp);
   endtask
   task automatic clk_wait(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic close_out;
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #40000;
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      close_out();
   end
   initial begin
      reset_n = 1'b0;
      io_addr = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
      error_cnt = 0;
      comparisons = 0;
      clk_wait(8);
      reset_n = 1'b1;
      rd(8'hed, 8'h00);
      rd(8'hec, 8'h00);
      rd(8'h10, 8'h00);
      $display("Test reset values done");
      wr(8'hed, 8'h01);
      wr(8'he0, 8'h3a);
      wr(8'he1, 8'h3b);
      wr(8'he2, 8'h17);
      wr(8'he3, 8'h07);
      wr(8'he4, 8'h1c);
      wr(8'he5, 8'h02);
      wr(8'he6, 8'h00);
      wr(8'he7, 8'h14);
      rd(8'he0, 8'h3a);
      wr(8'hed, 8'h00);
      poll_seconds(8'h00, 100);
      rd(8'he1, 8'h00);
      rd(8'he2, 8'h00);
      rd(8'he3, 8'h01);
      rd(8'he4, 8'h1d);
      rd(8'he5, 8'h02);
      wr(8'he1, 8'h05);
      rd(8'he1, 8'h00);
      $display("Test rollover done");
      wr(8'hed, 8'h09);
      rd(8'he4, 8'h29);
      wr(8'he0, 8'h59);
      wr(8'hed, 8'h01);
      rd(8'he0, 8'h3b);
      $display("Test format done");
      wr(8'he8, 8'h3b);
      wr(8'hec, 8'h01);
      wr(8'hed, 8'h00);
      clk_wait(3);
      check({7'h00, irq}, 8'h00);
      rd(8'hed, 8'h20);
      wr(8'hed, 8'h10);
      clk_wait(2);
      check({7'h00, irq}, 8'h01);
      rd(8'hed, 8'h30);
      check({7'h00, irq}, 8'h00);
      rd(8'hed, 8'h10);
      wr(8'he9, 8'h2a);
      wr(8'hec, 8'h03);
      rd(8'hec, 8'h03);
      wr(8'hed, 8'h01);
      wr(8'he0, 8'h3b);
      wr(8'hed, 8'h10);
      clk_wait(3);
      check({7'h00, irq}, 8'h00);
      rd(8'hed, 8'h10);
      $display("Test alarm done");
      wr(8'hed, 8'h01);
      wr(8'he0, 8'h2a);
      reset_n = 1'b0;
      clk_wait(2);
      reset_n = 1'b1;
      rd(8'he0, 8'h2a);
      rd(8'hed, 8'h00);
      rd(8'hec, 8'h00);
      $display("Test warm reset done");
      for (int f = 0; f < 2; f++) begin
         e = f ? 50 : 60;
         wr(8'hed, {5'h00, f[0], 2'b11});
         wr(8'he0, 8'h00);
         wr(8'hed, {5'h00, f[0], 2'b10});
         clk_wait(e * 11 / 2 - 20);
         rd(8'he0, 8'h00);
         poll_seconds(8'h01, 25);
      end
      $display("Test line source done");
      close_out();
   end
endmodule // calendar_clock_with_alarm_tb_top
`default_nettype wire
